// ===== rtl/etpc_pkg.sv
// Summary of operation
// - timer3 clock field codes 000-110 pick internal clocks, 111 picks timer3 pin.
// - run bit 0 stops and clears the counter; 1 starts counting.
// - timer3 mode: 000 timer, 001 divider, 010 pwm, 011 cascaded 16-bit.
// - cascade takes clock from timer3 field, run and level from timer4.
// - fields written with a 0-to-1 run change apply; level bit seeds flip-flop.
// - timer3 pulse-width register changes while running only in pwm modes.
// - timer4 has control, period, pulse-width registers with same write limits.
// - timer4 mode: 000-010 8-bit, 011 reserved, 100-111 16-bit modes.
// - timer4 mode top bit set makes timer4 count timer3 overflows when timer3 is in cascade mode (011).
package etpc_pkg;
   typedef struct packed {
      logic ff_ctl;
      logic [2:0] clk_sel;
      logic run;
      logic [2:0] mode;
   } etpc_ctl_s;

   localparam logic [7:0] CTL_RESET = 8'h00;
   localparam logic [7:0] PER_RESET = 8'h00;
   localparam logic [7:0] PW_RESET = 8'h00;
   localparam logic [7:0] CNT_FULL = 8'hff;

   localparam logic [9:0] IDX_CTL3 = 10'h018;
   localparam logic [9:0] IDX_CTL4 = 10'h019;
   localparam logic [9:0] IDX_PER3 = 10'h01a;
   localparam logic [9:0] IDX_PW3 = 10'h01b;
   localparam logic [9:0] IDX_PER4 = 10'h01c;
   localparam logic [9:0] IDX_PW4 = 10'h01d;
   localparam logic [9:0] IDX_STAT = 10'h01e;
   localparam logic [9:0] IDX_CFG = 10'h01f;

   localparam logic [2:0] CK_DIV11 = 3'h0;
   localparam logic [2:0] CK_DIV7 = 3'h1;
   localparam logic [2:0] CK_DIV5 = 3'h2;
   localparam logic [2:0] CK_DIV3 = 3'h3;
   localparam logic [2:0] CK_LF = 3'h4;
   localparam logic [2:0] CK_DIV1 = 3'h5;
   localparam logic [2:0] CK_HF = 3'h6;
   localparam logic [2:0] CK_PIN = 3'h7;

   localparam logic [2:0] M8_TIMER = 3'h0;
   localparam logic [2:0] M8_DIV = 3'h1;
   localparam logic [2:0] M8_PWM = 3'h2;
   localparam logic [2:0] M_CASC = 3'h3;
   localparam logic [2:0] M16_TIMER = 3'h4;
   localparam logic [2:0] M16_WARM = 3'h5;
   localparam logic [2:0] M16_PWM = 3'h6;
   localparam logic [2:0] M16_PPG = 3'h7;

   localparam int MODE_TOP_BIT = 2;
   localparam int PRESC_MIN_W = 11;
endpackage : etpc_pkg

// ===== rtl/etpc_sync.sv
`timescale 1ns/1ns
`default_nettype none
module etpc_sync (
   input wire logic clk,
   input wire logic rst_n,
   input wire logic async_in,
   output logic level,
   output logic rise
);
   logic s1_q, s2_q, s3_q, lvl_q;

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         s1_q <= 1'b0;
         s2_q <= 1'b0;
         s3_q <= 1'b0;
      end else begin
         s1_q <= async_in;
         s2_q <= s1_q;
         s3_q <= s2_q;
      end
   end

   // level moves once second and third stages agree
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         lvl_q <= 1'b0;
      end else if (s2_q == s3_q) begin
         lvl_q <= s3_q;
      end
   end

   assign level = lvl_q;
   assign rise = (s2_q == s3_q) & s3_q & ~lvl_q;
endmodule : etpc_sync
`default_nettype wire

// ===== rtl/etpc_top.sv
`timescale 1ns/1ns
`default_nettype none
module etpc_top
   import etpc_pkg::*;
#(
   parameter int PRESC_W = 11
) (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic low_freq_clock,
   input wire logic timer3_pin,
   input wire logic timer4_pin,
   output logic timer3_out,
   output logic timer4_out
);
   if (PRESC_W < PRESC_MIN_W) begin : g_chk
      $error("etpc_top: prescaler too narrow");
   end

   etpc_ctl_s ctl3_q, ctl4_q;
   logic [7:0] per3_q, pw3_q, per4_q, pw4_q;
   logic [7:0] cnt3_q, cnt4_q;
   logic ff3_q, ff4_q, run3_prev_q, run4_prev_q;
   logic div_src_q;
   logic [PRESC_W-1:0] presc_q;
   logic [2:0] lf_div_q;
   logic [31:0] prdata_q;
   logic pready_q, pslverr_q;
   logic lf_tick, pin3_tick, pin4_tick;

   etpc_sync u_lf (
      .clk(pclk),
      .rst_n(presetn),
      .async_in(low_freq_clock),
      .level(),
      .rise(lf_tick)
   );
   etpc_sync u_pin3 (
      .clk(pclk),
      .rst_n(presetn),
      .async_in(timer3_pin),
      .level(),
      .rise(pin3_tick)
   );
   etpc_sync u_pin4 (
      .clk(pclk),
      .rst_n(presetn),
      .async_in(timer4_pin),
      .level(),
      .rise(pin4_tick)
   );

   // prescaler chain from the fast clock and the slow-clock /8 stage
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         presc_q <= '0;
      end else begin
         presc_q <= presc_q + 1'b1;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         lf_div_q <= 3'h0;
      end else if (lf_tick) begin
         lf_div_q <= lf_div_q + 3'h1;
      end
   end

   function automatic logic tap(input int n);
      logic t;
      t = 1'b1;
      for (int i = 0; i < PRESC_MIN_W; i++) begin
         if (i < n) begin
            t = t & presc_q[i];
         end
      end
      return t;
   endfunction : tap

   function automatic logic sel_tick(input logic [2:0] sel, input logic pin_tick);
      logic t;
      unique case (sel)
         CK_DIV11: t = div_src_q ? (lf_tick & (&lf_div_q)) : tap(11);
         CK_DIV7: t = tap(7);
         CK_DIV5: t = tap(5);
         CK_DIV3: t = tap(3);
         CK_LF: t = lf_tick;
         CK_DIV1: t = tap(1);
         CK_HF: t = 1'b1;
         CK_PIN: t = pin_tick;
      endcase
      return t;
   endfunction : sel_tick

   // cascade and clock routing
   logic casc, t4_16, run3, run4, tk3, tk4, carry3, match16, pwm16_hit;
   assign casc = (ctl3_q.mode == M_CASC);
   assign t4_16 = ctl4_q.mode[MODE_TOP_BIT];
   assign run3 = casc ? ctl4_q.run : ctl3_q.run;
   assign run4 = ctl4_q.run;
   always_comb tk3 = sel_tick(ctl3_q.clk_sel, pin3_tick);
   assign carry3 = run3 & tk3 & casc & (cnt3_q == CNT_FULL);
   always_comb tk4 = t4_16 ? carry3 : sel_tick(ctl4_q.clk_sel, pin4_tick);
   assign match16 = ({cnt4_q, cnt3_q} == {per4_q, per3_q});
   assign pwm16_hit = ({cnt4_q, cnt3_q} == {pw4_q, pw3_q});

   // timer3 low byte counter
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         cnt3_q <= 8'h00;
      end else if (!run3) begin
         cnt3_q <= 8'h00;
      end else if (tk3) begin
         if (casc) begin
            cnt3_q <= (match16 && t4_16 && ctl4_q.mode != M16_PWM) ? 8'h00 : cnt3_q + 8'h01;
         end else begin
            unique case (ctl3_q.mode)
               M8_TIMER, M8_DIV: cnt3_q <= (cnt3_q == per3_q) ? 8'h00 : cnt3_q + 8'h01;
               default: cnt3_q <= cnt3_q + 8'h01;
            endcase
         end
      end
   end

   // timer4 counter, upper byte in 16-bit modes
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         cnt4_q <= 8'h00;
      end else if (!run4) begin
         cnt4_q <= 8'h00;
      end else if (t4_16) begin
         if (casc && tk3 && match16 && ctl4_q.mode != M16_PWM) begin
            cnt4_q <= 8'h00;
         end else if (tk4) begin
            cnt4_q <= cnt4_q + 8'h01;
         end
      end else if (tk4) begin
         unique case (ctl4_q.mode)
            M8_TIMER, M8_DIV: cnt4_q <= (cnt4_q == per4_q) ? 8'h00 : cnt4_q + 8'h01;
            M8_PWM: cnt4_q <= cnt4_q + 8'h01;
            default: cnt4_q <= cnt4_q;
         endcase
      end
   end

   // flip-flop outputs, seeded from the level bit at start
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         run3_prev_q <= 1'b0;
         run4_prev_q <= 1'b0;
      end else begin
         run3_prev_q <= run3;
         run4_prev_q <= run4;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ff3_q <= 1'b0;
      end else if (run3 && !run3_prev_q && !casc) begin
         ff3_q <= ctl3_q.ff_ctl;
      end else if (run3 && tk3 && !casc) begin
         if (ctl3_q.mode == M8_DIV && cnt3_q == per3_q) begin
            ff3_q <= ~ff3_q;
         end else if (ctl3_q.mode == M8_PWM && (cnt3_q == pw3_q || cnt3_q == CNT_FULL)) begin
            ff3_q <= ~ff3_q;
         end
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ff4_q <= 1'b0;
      end else if (run4 && !run4_prev_q) begin
         ff4_q <= ctl4_q.ff_ctl;
      end else if (run4 && t4_16 && casc && tk3) begin
         if ((ctl4_q.mode == M16_TIMER || ctl4_q.mode == M16_PPG) && match16) begin
            ff4_q <= ~ff4_q;
         end else if (ctl4_q.mode == M16_PWM && (pwm16_hit || {cnt4_q, cnt3_q} == {CNT_FULL, CNT_FULL})) begin
            ff4_q <= ~ff4_q;
         end
      end else if (run4 && tk4 && !t4_16) begin
         if (ctl4_q.mode == M8_DIV && cnt4_q == per4_q) begin
            ff4_q <= ~ff4_q;
         end else if (ctl4_q.mode == M8_PWM && (cnt4_q == pw4_q || cnt4_q == CNT_FULL)) begin
            ff4_q <= ~ff4_q;
         end
      end
   end

   // APB slave: one wait state, write at the completing edge
   logic wr_done, rd_start;
   logic [9:0] widx;
   logic run3_ctl, run4_ctl, pwm3_ok, pwm4_ok;
   assign widx = paddr[11:2];
   assign wr_done = psel & penable & pready_q & pwrite;
   assign rd_start = psel & penable & ~pready_q;
   assign run3_ctl = casc ? ctl4_q.run : ctl3_q.run;
   assign pwm3_ok = (ctl3_q.mode == M8_PWM) || (casc && ctl4_q.mode == M16_PWM);
   assign pwm4_ok = (ctl4_q.mode == M8_PWM) || (ctl4_q.mode == M16_PWM);
   assign run4_ctl = ctl4_q.run;

   function automatic logic mapped(input logic [9:0] idx);
      return idx >= IDX_CTL3 && idx <= IDX_CFG;
   endfunction : mapped

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ctl3_q <= CTL_RESET;
         ctl4_q <= CTL_RESET;
      end else if (wr_done) begin
         if (widx == IDX_CTL3) begin
            if (ctl3_q.run) begin
               ctl3_q.run <= pwdata[3];
            end else begin
               ctl3_q <= pwdata[7:0];
            end
         end
         if (widx == IDX_CTL4) begin
            if (ctl4_q.run) begin
               ctl4_q.run <= pwdata[3];
            end else begin
               ctl4_q <= pwdata[7:0];
            end
         end
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         per3_q <= PER_RESET;
         pw3_q <= PW_RESET;
         per4_q <= PER_RESET;
         pw4_q <= PW_RESET;
         div_src_q <= 1'b0;
      end else if (wr_done) begin
         if (widx == IDX_PER3 && !run3_ctl) begin
            per3_q <= pwdata[7:0];
         end
         if (widx == IDX_PW3 && (!run3_ctl || pwm3_ok)) begin
            pw3_q <= pwdata[7:0];
         end
         if (widx == IDX_PER4 && !run4_ctl) begin
            per4_q <= pwdata[7:0];
         end
         if (widx == IDX_PW4 && (!run4_ctl || pwm4_ok)) begin
            pw4_q <= pwdata[7:0];
         end
         if (widx == IDX_CFG) begin
            div_src_q <= pwdata[0];
         end
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pready_q <= 1'b0;
         pslverr_q <= 1'b0;
         prdata_q <= 32'h0000_0000;
      end else begin
         pready_q <= rd_start;
         pslverr_q <= rd_start & ~mapped(widx);
         if (rd_start && !pwrite) begin
            unique case (widx)
               IDX_CTL3: prdata_q <= {24'h00_0000, ctl3_q};
               IDX_CTL4: prdata_q <= {24'h00_0000, ctl4_q};
               IDX_PER3: prdata_q <= {24'h00_0000, per3_q};
               IDX_PW3: prdata_q <= {24'h00_0000, pw3_q};
               IDX_PER4: prdata_q <= {24'h00_0000, per4_q};
               IDX_PW4: prdata_q <= {24'h00_0000, pw4_q};
               IDX_STAT: prdata_q <= {14'h0000, ff4_q, ff3_q, cnt4_q, cnt3_q};
               IDX_CFG: prdata_q <= {31'h0000_0000, div_src_q};
               default: prdata_q <= 32'h0000_0000;
            endcase
         end
      end
   end

   assign prdata = prdata_q;
   assign pready = pready_q;
   assign pslverr = pslverr_q;
   assign timer3_out = ff3_q;
   assign timer4_out = ff4_q;
endmodule : etpc_top
`default_nettype wire

// ===== dv/etpc_chk_sva.sv
`timescale 1ns/1ns
`default_nettype none
module etpc_chk
   import etpc_pkg::*;
#(
   parameter int PRESC_W = 11
) (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] prdata,
   input wire logic pready,
   input wire logic pslverr,
   input wire logic timer3_out,
   input wire logic timer4_out
);
   default clocking cb @(posedge pclk);
   endclocking
   default disable iff (!presetn);
   chk_ready_one: assert property (pready |=> !pready)
      else $error("pready held past one cycle");
   chk_ready_late: assert property (psel && !penable ##1 psel && penable |=> pready)
      else $error("pready not in second access cycle");
   chk_ready_access: assert property (pready |-> psel && penable)
      else $error("pready outside access phase");
   chk_err_ready: assert property (pslverr |-> pready)
      else $error("pslverr without pready");
   chk_err_decode: assert property (pready |-> pslverr == (paddr[11:2] < IDX_CTL3 || paddr[11:2] > IDX_CFG))
      else $error("pslverr wrong for address");
   chk_err_zero: assert property (pready && pslverr && !pwrite |-> prdata == 32'h0)
      else $error("unmapped read not zero");
   chk_byte_read: assert property (pready && !pwrite && paddr[11:2] != IDX_STAT |-> prdata[31:8] == 24'h0)
      else $error("upper read bits not zero");
   chk_rdata_hold: assert property ($changed(prdata) |-> pready && !pwrite)
      else $error("prdata moved outside a read");
   chk_out_reset: assert property ($rose(presetn) |-> !timer3_out && !timer4_out)
      else $error("timer outputs set after reset");
endmodule : etpc_chk
bind etpc_top etpc_chk #(.PRESC_W(PRESC_W)) etpc_chk_i (.pclk(pclk), .presetn(presetn), .psel(psel),
   .penable(penable), .pwrite(pwrite), .paddr(paddr), .prdata(prdata), .pready(pready), .pslverr(pslverr),
   .timer3_out(timer3_out), .timer4_out(timer4_out));
`default_nettype wire

// ===== dv/etpc_pins.sv
`timescale 1ns/1ns
`default_nettype none
module etpc_pins (
   input wire logic clk,
   input wire logic start,
   input wire logic [8:0] count,
   output logic pin3,
   output logic pin4,
   output logic slow_clk,
   output logic busy
);
   logic [8:0] left_q = '0;
   logic [2:0] ph_q = '0;
   logic [3:0] sc_q = '0;
   // pins idle low between bursts
   assign busy = left_q != 9'h000;
   assign pin3 = busy & ph_q[2];
   assign pin4 = pin3;
   assign slow_clk = sc_q[3];
   always @(posedge clk) begin
      sc_q <= sc_q + 4'h1;
      ph_q <= busy ? ph_q + 3'h1 : 3'h0;
      if (start) begin
         left_q <= count;
      end else if (busy && ph_q == 3'h7) begin
         left_q <= left_q - 9'h001;
      end
   end
endmodule : etpc_pins
`default_nettype wire

// ===== dv/eight_bit_timer_pair_control_bench.sv
`timescale 1ns/1ns
`default_nettype none
`define CHK(n, e, g) begin checks_done++; if ((g) !== (e)) begin fails++; $display("mismatch %s exp %h got %h", n, e, g); end end
module eight_bit_timer_pair_control_bench;
   import etpc_pkg::*;
   localparam logic [11:0] A3 = {IDX_CTL3, 2'b00};
   localparam logic [11:0] A4 = {IDX_CTL4, 2'b00};
   localparam logic [11:0] AP = {IDX_PER3, 2'b00};
   localparam logic [11:0] AS = {IDX_STAT, 2'b00};
   logic pclk = 0;
   logic presetn = 0;
   logic psel = 0;
   logic penable = 0;
   logic pwrite = 0;
   logic go = 0;
   logic [11:0] paddr = '0;
   logic [31:0] pwdata = '0;
   logic [8:0] cnt = '0;
   logic [31:0] prdata, rd;
   logic pready, pslverr, er, lf, p3, p4, t3o, t4o, busy;
   logic [7:0] r = 8'h1e;
   logic [7:0] pv;
   logic [8:0] np;
   logic [17:0] ex;
   int fails = 0;
   int checks_done = 0;
   always #20 pclk = ~pclk;
   etpc_top #(.PRESC_W(11)) etpc_top_i (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .low_freq_clock(lf), .timer3_pin(p3), .timer4_pin(p4), .timer3_out(t3o), .timer4_out(t4o));
   etpc_pins etpc_pins_i (.clk(pclk), .start(go), .count(cnt), .pin3(p3), .pin4(p4), .slow_clk(lf),
      .busy(busy));
   function automatic logic [7:0] nxt(input logic [7:0] x);
      return {x[6:0], x[7] ^ x[5] ^ x[4] ^ x[3]};
   endfunction : nxt
   function automatic logic [7:0] ctl(input logic f, input logic [2:0] c, input logic g, input logic [2:0] m);
      return {f, c, g, m};
   endfunction : ctl
   // timer3 pwm from 0 with level 0, timer4 divider from 0 with level 1
   function automatic logic [17:0] pred(input logic [8:0] n, input logic [7:0] p4, input logic [7:0] w3);
      logic f3, f4;
      logic [7:0] c3, c4;
      f3 = 1'b0;
      f4 = 1'b1;
      c3 = 8'h00;
      c4 = 8'h00;
      for (int k = 0; k < n; k++) begin
         if (c3 == w3 || c3 == 8'hff) begin
            f3 = ~f3;
         end
         c3 = c3 + 8'h01;
         if (c4 == p4) begin
            f4 = ~f4;
            c4 = 8'h00;
         end else begin
            c4 = c4 + 8'h01;
         end
      end
      return {f4, f3, c4, c3};
   endfunction : pred
   task automatic wrap_up(input logic to);
      if (to) fails++;
      $display("checks %0d mismatches %0d", checks_done, fails);
      if (fails == 0 && checks_done > 0) begin
         $display("Testbench passed");
      end else begin
         $display("Testbench failed");
      end
      $finish;
   endtask : wrap_up
   task automatic apb(input logic w, input logic [11:0] a, input logic [7:0] d);
      int n;
      n = 0;
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= {24'h0, d};
      @(posedge pclk);
      penable <= 1'b1;
      do begin
         @(posedge pclk);
         n++;
         if (n > 20) wrap_up(1'b1);
      end while (pready !== 1'b1);
      rd = prdata;
      er = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge pclk);
   endtask : apb
   task automatic wr(input logic [11:0] a, input logic [7:0] d);
      apb(1'b1, a, d);
   endtask : wr
   task automatic rchk(input logic [11:0] a, input logic [31:0] e, input logic [31:0] m);
      apb(1'b0, a, 8'h00);
      `CHK("read", e, rd & m)
   endtask : rchk
   task automatic pulse(input logic [8:0] n);
      int k;
      k = 0;
      cnt <= n;
      go <= 1'b1;
      @(posedge pclk);
      go <= 1'b0;
      while (busy !== 1'b0 || k < 2) begin
         @(posedge pclk);
         k++;
         if (k > 3000) wrap_up(1'b1);
      end
      repeat (6) @(posedge pclk);
   endtask : pulse
   initial begin
      repeat (5) @(posedge pclk);
      presetn <= 1'b1;
      @(posedge pclk);
      rchk(A3, 32'h0, 32'hffffffff);
      rchk(AS, 32'h0, 32'hffffffff);
      apb(1'b0, 12'h000, 8'h00);
      `CHK("err", 1'b1, er)
      for (int i = 0; i < 8; i++) begin
         r = nxt(r);
         wr(A3, ctl(r[7], 3'(i), 1'b0, r[2:0]));
         rchk(A3, {24'h0, ctl(r[7], 3'(i), 1'b0, r[2:0])}, 32'hffffffff);
         wr(A4, ctl(r[6], r[5:3], 1'b0, 3'(i)));
         rchk(A4, {24'h0, ctl(r[6], r[5:3], 1'b0, 3'(i))}, 32'hffffffff);
         r = nxt(r);
         wr(AP + 12'(4 * (i % 4)), r);
         rchk(AP + 12'(4 * (i % 4)), {24'h0, r}, 32'hffffffff);
      end
      wr(AP, 8'hff);
      wr(AP + 12'h8, 8'hff);
      wr(AP + 12'hc, 8'h00);
      wr(A3, 8'hf8);
      wr(A4, 8'h78);
      pulse(9'd20);
      rchk(AS, 32'h00011414, 32'h3ffff);
      `CHK("ff3", 1'b1, t3o)
      wr(AP, 8'h10);
      rchk(AP, 32'hff, 32'hff);
      wr(A3, 8'h88);
      rchk(A3, 32'hf8, 32'hff);
      wr(AP + 12'hc, 8'h33);
      rchk(AP + 12'hc, 32'h0, 32'hff);
      wr(A3, 8'h00);
      rchk(A3, 32'hf0, 32'hff);
      rchk(AS, 32'h0, 32'hff);
      wr(A4, 8'h00);
      wr(A3, ctl(1'b0, CK_PIN, 1'b0, M_CASC));
      wr(A4, ctl(1'b0, CK_PIN, 1'b1, M16_TIMER));
      pulse(9'd300);
      rchk(AS, 32'h012c, 32'hffff);
      wr(A4, 8'h70);
      wr(A3, ctl(1'b0, CK_HF, 1'b1, M8_PWM));
      wr(AP + 12'h4, 8'h5a);
      rchk(AP + 12'h4, 32'h5a, 32'hff);
      wr(AP + 12'h14, 8'h01);
      rchk(AP + 12'h14, 32'h1, 32'hffffffff);
      wr(A3, 8'h00);
      r = nxt(r);
      pv = {4'h0, r[3:0]};
      wr(AP + 12'h8, pv);
      r = nxt(r);
      np = {1'b0, r} + 9'd20;
      wr(A3, ctl(1'b0, CK_PIN, 1'b1, M8_PWM));
      wr(A4, ctl(1'b1, CK_PIN, 1'b1, M8_DIV));
      pulse(np);
      ex = pred(np, pv, 8'h5a);
      rchk(AS, {14'h0, ex}, 32'h3ffff);
      `CHK("t3o", ex[16], t3o)
      `CHK("t4o", ex[17], t4o)
      wrap_up(1'b0);
   end
endmodule : eight_bit_timer_pair_control_bench
`default_nettype wire
